// [lcdp_pin_if.sv]
// Pin multiplexer of the LCD panel and palette DAC output interface.
//
// Chosen here: the plain strobed port and the placing of the registers.

module lcdp_pin_if (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [lcdp_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [lcdp_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [lcdp_pkg::DATA_W-1:0] reg_rdata,
  input wire logic sdram_select,
  input wire logic suspend_mode,
  input wire logic sleep_mode,
  input wire logic pixel_clock_src,
  input wire logic line_sync_src,
  input wire logic frame_sync_src,
  input wire logic show_enable_src,
  input wire logic [3:0] tft_red,
  input wire logic [3:0] tft_green,
  input wire logic [3:0] tft_blue,
  input wire logic [7:0] stn_upper,
  input wire logic [7:0] stn_lower,
  input wire logic [7:0] dac_pixel,
  input wire logic backlight_request_in,
  output logic backlight_request_out,
  output logic backlight_request_oe,
  input wire logic panel_drive_power_request_in,
  output logic panel_drive_power_request_out,
  output logic panel_drive_power_request_oe,
  input wire logic panel_logic_power_request_in,
  output logic panel_logic_power_request_out,
  output logic panel_logic_power_request_oe,
  output logic line_latch_pulse,
  output logic frame_pulse,
  output logic panel_show_enable,
  output logic pixel_clock,
  output logic [7:0] upper_pixel_bus,
  output logic [7:0] lower_pixel_bus
);

  lcdp_dac_if dac ();

  lcdp_dac_writer u_writer (
    .clk(clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .dac(dac)
  );

  lcdp_pkg::lcdp_panel_t panel_q;
  logic logic_on_bl_q;
  logic [2:0] power_q;
  logic [2:0] gpio_sel_q;
  logic [2:0] gpio_dir_q;
  logic [2:0] gpio_out_q;
  logic [2:0] pin_s1_q;
  logic [2:0] pin_s2_q;
  logic [3:0] tim_s1_q;
  logic [3:0] tim_s2_q;
  logic pclk_last_q;
  logic start_q;
  logic [7:0] dac_wdata_q;
  logic [1:0] dac_waddr_q;
  logic cke_q;
  logic is_dac;
  logic pclk_rise;
  logic [2:0] pin_out_d;
  logic [2:0] pin_oe_d;

  // Register index match, used with the write strobe.
  function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
    return a == r;
  endfunction

  // ==========================================================
  // Register writes
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      panel_q <= lcdp_pkg::lcdp_panel_t'(lcdp_pkg::PANEL_RST);
      logic_on_bl_q <= 1'b0;
    end else if (clk_en && reg_write && hit(reg_addr, lcdp_pkg::REG_CONFIG))
    begin
      panel_q <= lcdp_pkg::lcdp_panel_t'(
        reg_wdata[lcdp_pkg::CFG_PANEL_LSB +: 2]);
      logic_on_bl_q <= reg_wdata[lcdp_pkg::CFG_LOGIC_ON_BL];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      power_q <= lcdp_pkg::PIN3_RST;
    end else if (clk_en && reg_write && hit(reg_addr, lcdp_pkg::REG_POWER))
    begin
      power_q <= reg_wdata[2:0];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      gpio_sel_q <= lcdp_pkg::PIN3_RST;
      gpio_dir_q <= lcdp_pkg::PIN3_RST;
      gpio_out_q <= lcdp_pkg::PIN3_RST;
    end else if (clk_en && reg_write) begin
      if (hit(reg_addr, lcdp_pkg::REG_GPIO_SEL)) begin
        gpio_sel_q <= reg_wdata[2:0];
      end
      if (hit(reg_addr, lcdp_pkg::REG_GPIO_DIR)) begin
        gpio_dir_q <= reg_wdata[2:0];
      end
      if (hit(reg_addr, lcdp_pkg::REG_GPIO_OUT)) begin
        gpio_out_q <= reg_wdata[2:0];
      end
    end
  end

  // A write to the command register launches one DAC register write unless the writer is still busy.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      start_q <= 1'b0;
      dac_wdata_q <= 8'h00;
      dac_waddr_q <= 2'h0;
    end else if (clk_en) begin
      start_q <= reg_write && hit(reg_addr, lcdp_pkg::REG_DAC_CMD);
      if (reg_write && hit(reg_addr, lcdp_pkg::REG_DAC_CMD)) begin
        dac_wdata_q <= reg_wdata[7:0];
        dac_waddr_q <= reg_wdata[lcdp_pkg::DAC_ADDR_LSB +: 2];
      end
    end
  end

  assign dac.start = start_q;
  assign dac.wdata = dac_wdata_q;
  assign dac.waddr = dac_waddr_q;

  // ==========================================================
  // Register reads
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 16'h0000;
    end else if (clk_en) begin
      reg_rdata <= 16'h0000;
      if (reg_read) begin
        unique case (reg_addr)
          lcdp_pkg::REG_CONFIG:
            reg_rdata <= {13'h0000, logic_on_bl_q, panel_q};
          lcdp_pkg::REG_POWER: reg_rdata <= {13'h0000, power_q};
          lcdp_pkg::REG_GPIO_SEL: reg_rdata <= {13'h0000, gpio_sel_q};
          lcdp_pkg::REG_GPIO_DIR: reg_rdata <= {13'h0000, gpio_dir_q};
          lcdp_pkg::REG_GPIO_OUT: reg_rdata <= {13'h0000, gpio_out_q};
          lcdp_pkg::REG_GPIO_IN:
            reg_rdata <= {13'h0000, pin_s2_q};
          lcdp_pkg::REG_DAC_CMD:
            reg_rdata <= {6'h00, dac_waddr_q, dac_wdata_q};
          lcdp_pkg::REG_STATUS:
            reg_rdata <= {13'h0000, sdram_select, cke_q, dac.busy};
          default: reg_rdata <= 16'h0000;
        endcase
      end
    end
  end

  // ==========================================================
  // Synchronisers for pins and engine timing
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_s1_q <= 3'h0;
      pin_s2_q <= 3'h0;
    end else if (clk_en) begin
      pin_s1_q <= {panel_logic_power_request_in,
                   panel_drive_power_request_in, backlight_request_in};
      pin_s2_q <= pin_s1_q;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tim_s1_q <= 4'h0;
      tim_s2_q <= 4'h0;
      pclk_last_q <= 1'b0;
    end else if (clk_en) begin
      tim_s1_q <= {pixel_clock_src, show_enable_src, frame_sync_src,
                   line_sync_src};
      tim_s2_q <= tim_s1_q;
      pclk_last_q <= tim_s2_q[3];
    end
  end

  assign is_dac = (panel_q == lcdp_pkg::LCDP_EXT_DAC);
  assign pclk_rise = tim_s2_q[3] && !pclk_last_q;

  // ==========================================================
  // Timing strobes: one pin serves every panel type.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      line_latch_pulse <= 1'b0;
      frame_pulse <= 1'b0;
      panel_show_enable <= 1'b0;
      pixel_clock <= 1'b0;
    end else if (clk_en) begin
      line_latch_pulse <= tim_s2_q[0];
      frame_pulse <= tim_s2_q[1];
      panel_show_enable <= tim_s2_q[2];
      pixel_clock <= tim_s2_q[3];
    end
  end

  // ==========================================================
  // Pixel buses, updated on each pixel clock rise; in DAC mode the upper bus on every cycle.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      upper_pixel_bus <= 8'h00;
      lower_pixel_bus <= 8'h00;
    end else if (clk_en && (pclk_rise || is_dac)) begin
      unique case (panel_q)
        lcdp_pkg::LCDP_TFT: begin
          upper_pixel_bus <= {tft_red, 2'h0, tft_green[3:2]};
          lower_pixel_bus <= {tft_green[1:0], 2'h0, tft_blue};
        end
        lcdp_pkg::LCDP_STN_SINGLE: begin
          upper_pixel_bus <= 8'h00;
          lower_pixel_bus <= stn_lower;
        end
        lcdp_pkg::LCDP_STN_DUAL: begin
          upper_pixel_bus <= stn_upper;
          lower_pixel_bus <= stn_lower;
        end
        lcdp_pkg::LCDP_EXT_DAC: begin
          // Write data must stand before the strobe falls, so it follows
          // the writer every cycle instead of waiting for a pixel clock.
          upper_pixel_bus <= dac.data_out;
          if (pclk_rise) begin
            lower_pixel_bus <= dac_pixel;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Request pins
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cke_q <= 1'b1;
    end else if (clk_en) begin
      cke_q <= !(suspend_mode || sleep_mode);
    end
  end

  always_comb begin
    pin_out_d = power_q;
    pin_oe_d = 3'h7;
    if (logic_on_bl_q) begin
      pin_out_d[lcdp_pkg::PIN_BACKLIGHT] = power_q[lcdp_pkg::PIN_LOGIC];
    end
    for (int i = 0; i < 3; i++) begin
      if (gpio_sel_q[i]) begin
        pin_out_d[i] = gpio_out_q[i];
        pin_oe_d[i] = gpio_dir_q[i];
      end
    end
    if (sdram_select) begin
      pin_out_d[lcdp_pkg::PIN_LOGIC] = cke_q;
      pin_oe_d[lcdp_pkg::PIN_LOGIC] = 1'b1;
    end
    if (is_dac) begin
      pin_out_d = {dac.addr_out, dac.strobe_n};
      pin_oe_d = 3'h7;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      backlight_request_out <= 1'b0;
      backlight_request_oe <= 1'b1;
      panel_drive_power_request_out <= 1'b0;
      panel_drive_power_request_oe <= 1'b1;
      panel_logic_power_request_out <= 1'b0;
      panel_logic_power_request_oe <= 1'b1;
    end else if (clk_en) begin
      backlight_request_out <= pin_out_d[lcdp_pkg::PIN_BACKLIGHT];
      backlight_request_oe <= pin_oe_d[lcdp_pkg::PIN_BACKLIGHT];
      panel_drive_power_request_out <= pin_out_d[lcdp_pkg::PIN_DRIVE];
      panel_drive_power_request_oe <= pin_oe_d[lcdp_pkg::PIN_DRIVE];
      panel_logic_power_request_out <= pin_out_d[lcdp_pkg::PIN_LOGIC];
      panel_logic_power_request_oe <= pin_oe_d[lcdp_pkg::PIN_LOGIC];
    end
  end

  // ==========================================================
  // Checks
  a_dac_strobe_pin: assert property (@(posedge clk) disable iff (!reset_n)
    (clk_en && is_dac) |=> backlight_request_oe &&
      backlight_request_out == $past(dac.strobe_n))
    else $error("Backlight pin does not carry the DAC strobe.");

  a_dac_addr_pins: assert property (@(posedge clk) disable iff (!reset_n)
    (clk_en && is_dac) |=> panel_drive_power_request_oe &&
      panel_drive_power_request_out == $past(dac.addr_out[0]))
    else $error("Drive pin does not carry DAC address bit 0.");

  a_dac_addr_hi: assert property (@(posedge clk) disable iff (!reset_n)
    (clk_en && is_dac) |=> panel_logic_power_request_oe &&
      panel_logic_power_request_out == $past(dac.addr_out[1]))
    else $error("Logic pin does not carry DAC address bit 1.");

  a_line_latency: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en [*3] |=> line_latch_pulse == $past(line_sync_src, 3))
    else $error("Line latch pulse does not follow the line sync.");

  a_show_latency: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en [*3] |=> panel_show_enable == $past(show_enable_src, 3))
    else $error("Show enable does not follow its source.");

  a_tft_pixel_map: assert property (@(posedge clk) disable iff (!reset_n)
    (clk_en && pclk_rise && panel_q == lcdp_pkg::LCDP_TFT) |=>
      upper_pixel_bus == {$past(tft_red), 2'h0, $past(tft_green[3:2])} &&
      lower_pixel_bus == {$past(tft_green[1:0]), 2'h0, $past(tft_blue)})
    else $error("TFT pixel bits placed wrongly.");

  a_dac_pixel_map: assert property (@(posedge clk) disable iff (!reset_n)
    (clk_en && pclk_rise && is_dac) |=>
      lower_pixel_bus == $past(dac_pixel) &&
      upper_pixel_bus == $past(dac.data_out))
    else $error("DAC pixel or register data placed wrongly.");

  a_sdram_cke_low: assert property (@(posedge clk) disable iff (!reset_n)
    (clk_en && sdram_select && !is_dac && (suspend_mode || sleep_mode))
      ##1 (clk_en && sdram_select && !is_dac) |=>
      !panel_logic_power_request_out)
    else $error("SDRAM clock enable not low in suspend or sleep.");

  a_backlight_level: assert property (@(posedge clk) disable iff (!reset_n)
    (clk_en && !is_dac && !gpio_sel_q[0] && !logic_on_bl_q) |=>
      backlight_request_out == $past(power_q[0]))
    else $error("Backlight request does not follow its setting.");

  a_gpio_input: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en [*2] |=> pin_s2_q[1] == $past(panel_drive_power_request_in, 2))
    else $error("GPIO input value not captured.");

endmodule

// [lcdp_pkg.sv]
// Constants, types and register map of the LCD panel pin interface.
package lcdp_pkg;

  // ==========================================================
  // Clock and timing
  localparam int CLK_MHZ = 40;
  localparam int DAC_SETUP_NS = 20;
  localparam int DAC_PULSE_NS = 50;
  localparam int DAC_HOLD_NS = 20;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] DAC_SETUP_CYC =
    CNT_W'((DAC_SETUP_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] DAC_PULSE_CYC =
    CNT_W'((DAC_PULSE_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] DAC_HOLD_CYC =
    CNT_W'((DAC_HOLD_NS * CLK_MHZ + 999) / 1000);

  // ==========================================================
  // Modes
  typedef enum logic [1:0] {
    LCDP_TFT = 2'h0,
    LCDP_STN_SINGLE = 2'h1,
    LCDP_STN_DUAL = 2'h2,
    LCDP_EXT_DAC = 2'h3
  } lcdp_panel_t;

  typedef enum logic [1:0] {
    LCDP_IDLE = 2'h0,
    LCDP_SETUP = 2'h1,
    LCDP_PULSE = 2'h3,
    LCDP_HOLD = 2'h2
  } lcdp_dac_state_t;

  // ==========================================================
  // Register map
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [3:0] REG_CONFIG = 4'h0;
  localparam logic [3:0] REG_POWER = 4'h1;
  localparam logic [3:0] REG_GPIO_SEL = 4'h2;
  localparam logic [3:0] REG_GPIO_DIR = 4'h3;
  localparam logic [3:0] REG_GPIO_OUT = 4'h4;
  localparam logic [3:0] REG_GPIO_IN = 4'h5;
  localparam logic [3:0] REG_DAC_CMD = 4'h6;
  localparam logic [3:0] REG_STATUS = 4'h7;

  // Field positions.
  localparam int CFG_PANEL_LSB = 0;
  localparam int CFG_LOGIC_ON_BL = 2;
  localparam int PIN_BACKLIGHT = 0;
  localparam int PIN_DRIVE = 1;
  localparam int PIN_LOGIC = 2;
  localparam int DAC_ADDR_LSB = 8;
  localparam int ST_BUSY = 0;
  localparam int ST_CKE = 1;
  localparam int ST_SDRAM = 2;

  // Reset values.
  localparam logic [1:0] PANEL_RST = 2'h0;
  localparam logic [2:0] PIN3_RST = 3'h0;

endpackage

// [lcdp_dac_if.sv]
// Interface between the pin multiplexer and the palette DAC writer.
interface lcdp_dac_if;
  logic start;
  logic [7:0] wdata;
  logic [1:0] waddr;
  logic busy;
  logic strobe_n;
  logic [7:0] data_out;
  logic [1:0] addr_out;

  modport ctrl (
    output start,
    output wdata,
    output waddr,
    input busy,
    input strobe_n,
    input data_out,
    input addr_out
  );

  modport writer (
    input start,
    input wdata,
    input waddr,
    output busy,
    output strobe_n,
    output data_out,
    output addr_out
  );
endinterface

// [lcdp_dac_writer.sv]
// Write cycle generator for the external palette DAC registers.
module lcdp_dac_writer (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  lcdp_dac_if.writer dac
);

  lcdp_pkg::lcdp_dac_state_t state_q;
  logic [lcdp_pkg::CNT_W-1:0] cnt_q;
  logic strobe_n_q;
  logic [7:0] data_q;
  logic [1:0] addr_q;

  // ==========================================================
  // Sequencer: setup, strobe low, hold.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= lcdp_pkg::LCDP_IDLE;
      cnt_q <= '0;
    end else if (clk_en) begin
      unique case (state_q)
        lcdp_pkg::LCDP_IDLE: begin
          if (dac.start) begin
            state_q <= lcdp_pkg::LCDP_SETUP;
            cnt_q <= lcdp_pkg::DAC_SETUP_CYC;
          end
        end
        lcdp_pkg::LCDP_SETUP: begin
          if (cnt_q == 4'h1) begin
            state_q <= lcdp_pkg::LCDP_PULSE;
            cnt_q <= lcdp_pkg::DAC_PULSE_CYC;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        lcdp_pkg::LCDP_PULSE: begin
          if (cnt_q == 4'h1) begin
            state_q <= lcdp_pkg::LCDP_HOLD;
            cnt_q <= lcdp_pkg::DAC_HOLD_CYC;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        lcdp_pkg::LCDP_HOLD: begin
          if (cnt_q == 4'h1) begin
            state_q <= lcdp_pkg::LCDP_IDLE;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
      endcase
    end
  end

  // A start while busy is ignored so the bus lines never move mid-cycle.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      data_q <= 8'h00;
      addr_q <= 2'h0;
    end else if (clk_en && dac.start && state_q == lcdp_pkg::LCDP_IDLE) begin
      data_q <= dac.wdata;
      addr_q <= dac.waddr;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      strobe_n_q <= 1'b1;
    end else if (clk_en) begin
      strobe_n_q <= !(state_q == lcdp_pkg::LCDP_SETUP && cnt_q == 4'h1) &&
                    !(state_q == lcdp_pkg::LCDP_PULSE && cnt_q != 4'h1);
    end
  end

  assign dac.busy = (state_q != lcdp_pkg::LCDP_IDLE);
  assign dac.strobe_n = strobe_n_q;
  assign dac.data_out = data_q;
  assign dac.addr_out = addr_q;

  // ==========================================================
  // Checks
  a_busy_holds_data: assert property (@(posedge clk) disable iff (!reset_n)
    (dac.busy && dac.start) |=> $stable(data_q))
    else $error("DAC write data changed during a write cycle.");

  a_strobe_in_busy: assert property (@(posedge clk) disable iff (!reset_n)
    !strobe_n_q |-> state_q != lcdp_pkg::LCDP_IDLE)
    else $error("DAC strobe active while the writer is idle.");

endmodule

// [lcdp_panel_model.sv]
// Behavioural panel and palette DAC seen at the far side of the pins.
module lcdp_panel_model (
  input wire logic clk,
  input wire logic dac_mode,
  input wire logic [2:0] ext_level,
  input wire logic [2:0] pin_out,
  input wire logic [2:0] pin_oe,
  input wire logic [7:0] upper_pixel_bus,
  output logic [2:0] pin_level,
  output logic [1:0] cap_addr,
  output logic [7:0] cap_data,
  output int cap_count,
  output int low_cycles
);
  timeunit 1ns;
  timeprecision 1ps;
  int low_run = 0;

  // A pin the device releases is driven by the board at a set level.
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      pin_level[i] = pin_oe[i] ? pin_out[i] : ext_level[i];
    end
  end

  // Measures how long the write strobe stays low.
  always @(posedge clk) begin
    if (dac_mode && !pin_level[0]) begin
      low_run <= low_run + 1;
    end else if (low_run != 0) begin
      low_cycles <= low_run;
      low_run <= 0;
    end
  end

  // Latches address and data on the strobe's rising edge, in DAC mode only.
  // Unused pixel pins are left unconnected here.
  always @(posedge pin_level[0]) begin
    if (dac_mode) begin
      cap_addr <= pin_level[2:1];
      cap_data <= upper_pixel_bus;
      cap_count <= cap_count + 1;
    end
  end
endmodule

// [lcdp_tb.sv]
// Self-checking testbench of the LCD panel pin interface.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset_n, clk_en, reg_write, reg_read, dac_mode, p;
  logic [3:0] reg_addr, red, green, blue, k;
  logic [15:0] reg_wdata, reg_rdata, v;
  logic sdram_select, suspend_mode, sleep_mode;
  logic pclk_src, line_src, frame_src, show_src;
  logic line_o, frame_o, show_o, pclk_o;
  logic rd_seen = 1'b0;
  logic [7:0] stn_up, stn_lo, dac_pix, upb, lob, d;
  logic [2:0] ext_level, pin_out, pin_oe, pin_level;
  logic [1:0] cap_addr;
  logic [7:0] cap_data;
  int cap_count, low_cycles, n;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [15:0] lfsr_q = 16'h8748;
  logic [15:0] exp_q[$];

  lcdp_pin_if i_lcdp_pin_if (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .sdram_select(sdram_select),
    .suspend_mode(suspend_mode), .sleep_mode(sleep_mode),
    .pixel_clock_src(pclk_src), .line_sync_src(line_src),
    .frame_sync_src(frame_src), .show_enable_src(show_src),
    .tft_red(red), .tft_green(green), .tft_blue(blue), .stn_upper(stn_up),
    .stn_lower(stn_lo), .dac_pixel(dac_pix),
    .backlight_request_in(pin_level[0]), .backlight_request_out(pin_out[0]),
    .backlight_request_oe(pin_oe[0]),
    .panel_drive_power_request_in(pin_level[1]),
    .panel_drive_power_request_out(pin_out[1]),
    .panel_drive_power_request_oe(pin_oe[1]),
    .panel_logic_power_request_in(pin_level[2]),
    .panel_logic_power_request_out(pin_out[2]),
    .panel_logic_power_request_oe(pin_oe[2]),
    .line_latch_pulse(line_o), .frame_pulse(frame_o),
    .panel_show_enable(show_o), .pixel_clock(pclk_o),
    .upper_pixel_bus(upb), .lower_pixel_bus(lob));

  lcdp_panel_model i_lcdp_panel_model (.clk(clk), .dac_mode(dac_mode),
    .ext_level(ext_level), .pin_out(pin_out), .pin_oe(pin_oe),
    .upper_pixel_bus(upb), .pin_level(pin_level), .cap_addr(cap_addr),
    .cap_data(cap_data), .cap_count(cap_count), .low_cycles(low_cycles));

  // ==========================================================
  // Clocks, checking and closing
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    pclk_src = 1'b0;
    #37;
    forever #100 pclk_src = ~pclk_src;
  end

  task automatic summarize;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Read data stands only in the cycle after the strobe.
  always @(posedge clk) begin
    cycles++;
    if (rd_seen && exp_q.size() != 0) begin
      chk(reg_rdata, exp_q.pop_front());
    end
    rd_seen <= reg_read;
    if (cycles == 20000) begin
      errors++;
      summarize();
    end
  end

  task automatic wr(input logic [3:0] a, input logic [15:0] dat);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= dat;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    reg_read <= 1'b0;
  endtask

  task automatic settle(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask

  function automatic logic [15:0] pix(input logic [1:0] m);
    case (m)
      2'h0: return {red, 2'h0, green[3:2], green[1:0], 2'h0, blue};
      2'h1: return {8'h00, stn_lo};
      2'h2: return {stn_up, stn_lo};
      default: return {8'h00, dac_pix};
    endcase
  endfunction

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // ==========================================================
  // Main sequence
  initial begin
    {clk_en, reset_n, reg_write, reg_read, dac_mode} = 5'h10;
    {sdram_select, suspend_mode, sleep_mode} = 3'h0;
    {line_src, frame_src, show_src, ext_level} = 6'h00;
    {reg_addr, reg_wdata, red, green, blue} = 32'h0;
    {stn_up, stn_lo, dac_pix} = 24'h0;
    repeat (10) @(posedge clk);
    chk({pin_oe, pin_out}, 16'h0038);
    reset_n <= 1'b1;
    rd(lcdp_pkg::REG_CONFIG, 16'h0000);
    rd(4'hF, 16'h0000);
    wr(lcdp_pkg::REG_POWER, 16'h0007);
    settle(3);
    chk(pin_out, 3'h7);
    wr(lcdp_pkg::REG_POWER, 16'h0002);
    settle(3);
    chk(pin_out, 3'h2);
    wr(lcdp_pkg::REG_CONFIG, 16'h0004);
    wr(lcdp_pkg::REG_POWER, 16'h0004);
    settle(3);
    chk(pin_out[0], 1'b1);
    rd(lcdp_pkg::REG_CONFIG, 16'h0004);
    wr(lcdp_pkg::REG_CONFIG, 16'h0000);
    $display("power request test done");
    ext_level <= 3'h5;
    wr(lcdp_pkg::REG_GPIO_SEL, 16'h0007);
    wr(lcdp_pkg::REG_GPIO_DIR, 16'h0000);
    settle(4);
    chk(pin_oe, 3'h0);
    rd(lcdp_pkg::REG_GPIO_IN, 16'h0005);
    wr(lcdp_pkg::REG_GPIO_DIR, 16'h0007);
    wr(lcdp_pkg::REG_GPIO_OUT, 16'h0006);
    wr(lcdp_pkg::REG_GPIO_IN, 16'hFFFF);
    settle(4);
    chk({pin_oe, pin_out}, 16'h003E);
    rd(lcdp_pkg::REG_GPIO_IN, 16'h0006);
    $display("port test done");
    sdram_select <= 1'b1;
    settle(4);
    chk({pin_oe[2], pin_out[2]}, 16'h0003);
    for (int i = 0; i < 2; i++) begin
      {suspend_mode, sleep_mode} <= 2'(i + 1);
      settle(4);
      chk(pin_out[2], 1'b0);
      rd(lcdp_pkg::REG_STATUS, 16'h0004);
    end
    {suspend_mode, sleep_mode, sdram_select} <= 3'h0;
    wr(lcdp_pkg::REG_GPIO_SEL, 16'h0000);
    wr(lcdp_pkg::REG_POWER, 16'h0007);
    settle(3);
    clk_en <= 1'b0;
    wr(lcdp_pkg::REG_POWER, 16'h0000);
    settle(3);
    chk(pin_out, 3'h7);
    clk_en <= 1'b1;
    $display("clock enable test done");
    for (int m = 0; m < 4; m++) begin
      wr(lcdp_pkg::REG_CONFIG, 16'(m));
      lfsr_q = lfsr_next(lfsr_q);
      v = lfsr_q;
      dac_mode <= (m == 3);
      {red, green, blue, line_src, frame_src, show_src} <= v[14:0];
      {stn_up, stn_lo} <= ~v;
      dac_pix <= v[11:4];
      settle(40);
      chk({line_o, frame_o, show_o}, v[2:0]);
      chk(m == 3 ? {8'h00, lob} : {upb, lob}, pix(2'(m)));
      p = pclk_o;
      settle(4);
      chk(pclk_o, !p);
    end
    chk(pin_oe, 3'h7);
    $display("panel mode test done");
    for (int j = 0; j < 5; j++) begin
      k = 4'(j);
      d = lfsr_q[7:0] ^ 8'(j * 37);
      n = cap_count;
      wr(lcdp_pkg::REG_DAC_CMD, {6'h00, k[1:0], d});
      if (j == 4) begin
        wr(lcdp_pkg::REG_DAC_CMD, 16'h00FF);
      end
      for (int i = 0; i < 60 && cap_count == n; i++) begin
        @(posedge clk);
      end
      settle(12);
      chk(16'(cap_count - n), 16'h0001);
      chk({6'h00, cap_addr, cap_data}, {6'h00, k[1:0], d});
      chk(16'(low_cycles), 16'(lcdp_pkg::DAC_PULSE_CYC));
      chk(upb, d);
    end
    rd(lcdp_pkg::REG_DAC_CMD, 16'h00FF);
    $display("palette write test done");
    settle(1);
    dac_mode <= 1'b0;
    reset_n <= 1'b0;
    settle(2);
    chk({pin_oe, pin_out}, 16'h0038);
    reset_n <= 1'b1;
    rd(lcdp_pkg::REG_CONFIG, 16'h0000);
    settle(3);
    $display("second reset test done");
    summarize();
  end
endmodule
